// ===== dcs_config_set.sv
/*
  Device option configuration set: loads the option record from an external
  configuration memory or falls back to built-in defaults, then applies the
  options to pull control, the charger-detect output, the wake input, idle
  power saving, pin states during USB suspend and the bridged HID target.
  Assumes all inputs are synchronous to clk and that the memory reader
  reports presence before or with its single load strobe.
*/
`timescale 1ns/1ps

// Functional notes
// - stored memory options override built-in defaults
// - six-pin weak pull option, default off
// - charger-detect indication can be disabled, default on
// - charger-detect polarity selectable, default active high
// - wake trigger rise/fall/high/low, default high
// - level trigger needs 1/5/30 ms, default 30
// - idle 5 s slows clock to 30 kHz
// - suspend pins keep, float, drive low or high
// - HID target address, zero means none present
// - descriptor start address, default zero, used fetching
// - target interrupt trigger selectable, default rising edge
// - HID subclass none or boot, default none
// - HID protocol none, keyboard or mouse
module dcs_config_set #(
  parameter int unsigned W_SHORT = dcs_pkg::LW_SHORT_CYC,
  parameter int unsigned W_MID = dcs_pkg::LW_MID_CYC,
  parameter int unsigned W_LONG = dcs_pkg::LW_LONG_CYC,
  parameter int unsigned IDLE = dcs_pkg::IDLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  // configuration memory side
  input wire logic cfg_present,
  input wire logic cfg_load,
  input dcs_pkg::dcs_cfg_t cfg_data,
  output logic cfg_ready,
  output dcs_pkg::dcs_cfg_t active_cfg,
  // charger detection
  input wire logic charger_detected,
  output logic charger_detect_out,
  // wake input
  input wire logic interrupt_wake_function,
  input wire logic wake_irq_pin,
  output logic wake_irq,
  // idle power saving
  input wire logic activity,
  output logic slow_clock_sel,
  // general-purpose pins, general_pin_zero at bit 0 up to general_pin_five
  input wire logic usb_suspend,
  input wire logic [5:0] func_pin_out,
  input wire logic [5:0] func_pin_oe,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic [5:0] pull_en,
  // HID-over-I2C target
  output logic hid_target_present,
  input wire logic desc_fetch_req,
  output logic desc_fetch_valid,
  output logic [15:0] desc_fetch_addr
);
  import dcs_pkg::*;

  dcs_top_st_t st;
  dcs_top_st_t next_st;

  // loader: defaults hold until the memory answers, then the record is frozen
  always_comb begin
    next_st = st;
    next_st.fetch_valid = 1'b0;
    unique case (st.state)
      ST_BOOT: begin
        if (cfg_present && cfg_load) begin
          next_st.cfg = cfg_data;
          next_st.state = ST_READY;
          next_st.ready = 1'b1;
        end else if (!cfg_present) begin
          // no memory fitted: run on the built-in record
          next_st.cfg = CFG_DEFAULT;
          next_st.state = ST_READY;
          next_st.ready = 1'b1;
        end
      end
      ST_READY: begin
        // later strobes are ignored; options are power-on values only
        next_st.state = ST_READY;
      end
      default: begin
        next_st.state = ST_BOOT;
        next_st.ready = 1'b0;
      end
    endcase

    // charger indication: disabled holds the inactive level
    if (st.cfg.chg_disable) begin
      next_st.chg_out = st.cfg.chg_active_low;
    end else begin
      next_st.chg_out = charger_detected ^ st.cfg.chg_active_low;
    end

    // weak pull applies to all six pins together
    next_st.pull_en = st.cfg.pull_en ? PINS_ALL : PINS_NONE;

    // suspend overrides the pin function only while suspend is asserted
    if (!usb_suspend) begin
      next_st.pin_out = func_pin_out;
      next_st.pin_oe = func_pin_oe;
    end else begin
      unique case (st.cfg.suspend_mode)
        SUSP_KEEP: begin
          next_st.pin_out = func_pin_out;
          next_st.pin_oe = func_pin_oe;
        end
        SUSP_TRISTATE: begin
          next_st.pin_out = PINS_NONE;
          next_st.pin_oe = PINS_NONE;
        end
        SUSP_DRIVE_LOW: begin
          next_st.pin_out = PINS_NONE;
          next_st.pin_oe = PINS_ALL;
        end
        SUSP_DRIVE_HIGH: begin
          next_st.pin_out = PINS_ALL;
          next_st.pin_oe = PINS_ALL;
        end
      endcase
    end

    // HID target: zero address means nothing is attached
    next_st.hid_present = (st.cfg.hid_addr != HID_ADDR_NONE);
    // descriptor fetches go out only to a present target
    if (desc_fetch_req && st.hid_present) begin
      next_st.fetch_valid = 1'b1;
      next_st.fetch_addr = st.cfg.hid_desc_addr;
    end
  end

  // reset loads defaults so consumers see sane options before loading ends
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{
        state: ST_BOOT,
        cfg: CFG_DEFAULT,
        ready: 1'b0,
        chg_out: 1'b0,
        pin_out: PINS_NONE,
        pin_oe: PINS_NONE,
        pull_en: PINS_NONE,
        hid_present: 1'b0,
        fetch_valid: 1'b0,
        fetch_addr: DESC_ADDR_ZERO
      };
    end else begin
      st <= next_st;
    end
  end

  // wake input qualification, only while the pin carries the wake function
  dcs_wake_qual #(
    .W_SHORT(W_SHORT),
    .W_MID(W_MID),
    .W_LONG(W_LONG)
  ) u_wake (
    .clk(clk),
    .reset(reset),
    .enable(interrupt_wake_function),
    .pin(wake_irq_pin),
    .trig(st.cfg.wake_trig),
    .width(st.cfg.level_width),
    .irq(wake_irq)
  );

  // idle timer gated by the power saving option
  dcs_idle_timer #(
    .IDLE(IDLE)
  ) u_idle (
    .clk(clk),
    .reset(reset),
    .enable(st.cfg.power_save_en),
    .activity(activity),
    .slow_sel(slow_clock_sel)
  );

  // all outputs but wake_irq and slow_clock_sel come from the state register
  assign cfg_ready = st.ready;
  assign active_cfg = st.cfg;
  assign charger_detect_out = st.chg_out;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign pull_en = st.pull_en;
  assign hid_target_present = st.hid_present;
  assign desc_fetch_valid = st.fetch_valid;
  assign desc_fetch_addr = st.fetch_addr;

  mem_override_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT && cfg_present && cfg_load) |=>
      (active_cfg == $past(cfg_data) && cfg_ready))
    else $error("memory options not taken");

  default_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT && !cfg_present) |=> (active_cfg == CFG_DEFAULT ##1 cfg_ready))
    else $error("defaults not used without memory");

  pull_follow_a: assert property (@(posedge clk) disable iff (reset)
    ##1 (pull_en == ($past(st.cfg.pull_en) ? PINS_ALL : PINS_NONE)))
    else $error("pull enables do not follow the option");

  chg_disable_a: assert property (@(posedge clk) disable iff (reset)
    st.cfg.chg_disable |=> (charger_detect_out == $past(st.cfg.chg_active_low)))
    else $error("disabled charger indication not inactive");

  chg_polarity_a: assert property (@(posedge clk) disable iff (reset)
    !st.cfg.chg_disable |=>
      (charger_detect_out == ($past(charger_detected) ^ $past(st.cfg.chg_active_low))))
    else $error("charger indication has wrong polarity");

  susp_drive_a: assert property (@(posedge clk) disable iff (reset)
    (usb_suspend && st.cfg.suspend_mode == SUSP_DRIVE_LOW) |=>
      (pin_oe == PINS_ALL && pin_out == PINS_NONE))
    else $error("pins not driven low in suspend");

  susp_float_a: assert property (@(posedge clk) disable iff (reset)
    (usb_suspend && st.cfg.suspend_mode == SUSP_TRISTATE) |=> (pin_oe == PINS_NONE))
    else $error("pins still driven in tristate suspend");

  awake_pins_a: assert property (@(posedge clk) disable iff (reset)
    !usb_suspend |=> (pin_out == $past(func_pin_out) && pin_oe == $past(func_pin_oe)))
    else $error("pin function changed outside suspend");

  hid_none_a: assert property (@(posedge clk) disable iff (reset)
    (st.cfg.hid_addr == HID_ADDR_NONE) |=> !hid_target_present ##1 !desc_fetch_valid)
    else $error("target reported with zero address");

  desc_fetch_a: assert property (@(posedge clk) disable iff (reset)
    (desc_fetch_req && st.hid_present) |=>
      (desc_fetch_valid && desc_fetch_addr == $past(st.cfg.hid_desc_addr)))
    else $error("descriptor fetch address wrong");

  // frozen record, and the wait on defaults while a fitted memory is silent
  cfg_frozen_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_READY) |=> (active_cfg == $past(active_cfg) && cfg_ready))
    else $error("options changed after loading ended");

  load_wait_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT && cfg_present && !cfg_load) |=> !cfg_ready)
    else $error("loading ended without a load strobe");

  // the record held from reset, field by field against the default values
  pull_default_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      (!active_cfg.pull_en && active_cfg.suspend_mode == SUSP_KEEP))
    else $error("wrong default for pulls or suspend pins");

  chg_default_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      (!active_cfg.chg_disable && !active_cfg.chg_active_low))
    else $error("wrong default for charger indication");

  wake_default_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      (active_cfg.wake_trig == TRIG_HIGH && active_cfg.level_width == LW_30MS))
    else $error("wrong default for wake trigger or width");

  save_default_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      active_cfg.power_save_en)
    else $error("power saving not on by default");

  hid_default_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      (active_cfg.hid_addr == HID_ADDR_NONE && active_cfg.hid_desc_addr == DESC_ADDR_ZERO))
    else $error("wrong default target addresses");

  hid_flags_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |-> (active_cfg.hid_irq_trig == TRIG_RISE &&
      !active_cfg.hid_idle_sup && !active_cfg.hid_proto_sup && !active_cfg.hid_power_sup))
    else $error("wrong default target trigger or flags");

  hid_class_a: assert property (@(posedge clk) disable iff (reset)
    (st.state == ST_BOOT) |->
      (active_cfg.hid_subclass == SUB_NONE && active_cfg.hid_protocol == PROTO_NONE))
    else $error("wrong default subclass or protocol");

  // remaining suspend cases, and the fetch port between accepted requests
  susp_high_a: assert property (@(posedge clk) disable iff (reset)
    (usb_suspend && st.cfg.suspend_mode == SUSP_DRIVE_HIGH) |=>
      (pin_oe == PINS_ALL && pin_out == PINS_ALL))
    else $error("pins not driven high in suspend");

  susp_keep_a: assert property (@(posedge clk) disable iff (reset)
    (usb_suspend && st.cfg.suspend_mode == SUSP_KEEP) |=>
      (pin_out == $past(func_pin_out) && pin_oe == $past(func_pin_oe)))
    else $error("pin function not kept in suspend");

  fetch_idle_a: assert property (@(posedge clk) disable iff (reset)
    !desc_fetch_req |=> !desc_fetch_valid)
    else $error("descriptor fetch without a request");

  fetch_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(desc_fetch_req && st.hid_present) |=> (desc_fetch_addr == $past(desc_fetch_addr)))
    else $error("descriptor address moved without a fetch");

  hid_seen_a: assert property (@(posedge clk) disable iff (reset)
    (st.cfg.hid_addr != HID_ADDR_NONE) |=> hid_target_present)
    else $error("target with an address not reported");

endmodule : dcs_config_set

// ===== dcs_idle_timer.sv
/*
  Idle timer for power saving: requests the slow system clock after a long
  stretch without activity and drops the request on any activity.
  Assumes activity is a synchronous level or pulse from the busy logic.
*/
`timescale 1ns/1ps
module dcs_idle_timer #(
  parameter int unsigned IDLE = dcs_pkg::IDLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic activity,
  output logic slow_sel
);
  import dcs_pkg::*;

  localparam logic [31:0] IDLE_LAST = 32'(IDLE - 1);

  dcs_idle_st_t st;
  dcs_idle_st_t next_st;

  // activity wins over the timeout so the clock is never slowed while busy
  always_comb begin
    next_st = st;
    if (!enable || activity) begin
      next_st.count = COUNT_ZERO;
      next_st.slow = 1'b0;
    end else if (st.count == IDLE_LAST) begin
      next_st.slow = 1'b1;
    end else begin
      next_st.count = st.count + COUNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slow_sel = st.slow;

  idle_wake_a: assert property (@(posedge clk) disable iff (reset)
    (activity || !enable) |=> !slow_sel)
    else $error("slow clock kept during activity or when disabled");

  idle_timeout_a: assert property (@(posedge clk) disable iff (reset)
    $rose(slow_sel) |-> $past(st.count) == IDLE_LAST)
    else $error("slow clock requested before the idle time");

endmodule : dcs_idle_timer

// ===== dcs_mem_model.sv
/*
  Behavioural model of the external configuration memory: reports presence
  and sends a load strobe a chosen number of cycles after reset release, plus a stray second one when extra is set.
  Assumes it shares clk and the synchronous reset with the configuration set.
*/
`timescale 1ns/1ps
module dcs_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic fitted,
  input wire logic extra,
  input wire logic [2:0] delay,
  input dcs_pkg::dcs_cfg_t record,
  output logic cfg_present,
  output logic cfg_load,
  output dcs_pkg::dcs_cfg_t cfg_data
);
  import dcs_pkg::*;
  logic [5:0] cnt;
  logic hit;
  // cycles since reset release; saturates so the strobe is never repeated by wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 6'h00;
    end else if (cnt != 6'h3f) begin
      cnt <= cnt + 6'h01;
    end
  end
  // prompt or slow load; a stray second strobe with wrong data only when asked
  assign hit = !reset && (cnt == {3'h0, delay});
  assign cfg_present = fitted;
  assign cfg_load = hit || (!reset && extra && cnt == {3'h0, delay} + 6'h03);
  // data is only valid with a real strobe; otherwise the inverse shows
  assign cfg_data = (fitted && hit) ? record : dcs_cfg_t'(~record);
endmodule : dcs_mem_model

// ===== dcs_pkg.sv
/*
  Shared types and constants for the device option configuration set:
  option encodings, the option record, its built-in defaults, timing counts
  and the state records of the configuration set, the wake qualifier and the idle timer.
  Assumes a 40 MHz system clock; every timing count is derived from it here.
*/
package dcs_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;

  // level-width choices, in milliseconds as printed
  localparam int unsigned LW_SHORT_MS = 1;
  localparam int unsigned LW_MID_MS = 5;
  localparam int unsigned LW_LONG_MS = 30;
  localparam int unsigned LW_SHORT_CYC = LW_SHORT_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned LW_MID_CYC = LW_MID_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned LW_LONG_CYC = LW_LONG_MS * (CLK_HZ / MS_PER_S);

  // idle time before the clock is slowed, in seconds as printed
  localparam int unsigned IDLE_S = 5;
  localparam int unsigned IDLE_CYC = IDLE_S * CLK_HZ;
  // rate the clock unit drops to while slowed; the clock unit owns the divider
  localparam int unsigned SLOW_CLK_KHZ = 30;

  // number of general-purpose pins under option control
  localparam int unsigned NUM_PINS = 6;
  localparam logic [5:0] PINS_ALL = 6'h3f;
  localparam logic [5:0] PINS_NONE = 6'h00;
  localparam logic [6:0] HID_ADDR_NONE = 7'h00;
  localparam logic [15:0] DESC_ADDR_ZERO = 16'h0000;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_HIGH = 2'h2,
    TRIG_LOW = 2'h3
  } dcs_trig_t;

  // code 3 is unused and falls back to the longest width
  typedef enum logic [1:0] {
    LW_1MS = 2'h0,
    LW_5MS = 2'h1,
    LW_30MS = 2'h2
  } dcs_lw_t;

  typedef enum logic [1:0] {
    SUSP_KEEP = 2'h0,
    SUSP_TRISTATE = 2'h1,
    SUSP_DRIVE_LOW = 2'h2,
    SUSP_DRIVE_HIGH = 2'h3
  } dcs_susp_t;

  typedef enum logic {
    SUB_NONE = 1'h0,
    SUB_BOOT = 1'h1
  } dcs_sub_t;

  typedef enum logic [1:0] {
    PROTO_NONE = 2'h0,
    PROTO_KEYBOARD = 2'h1,
    PROTO_MOUSE = 2'h2
  } dcs_proto_t;

  // the option record as held by the configuration memory
  typedef struct packed {
    logic pull_en;
    logic chg_disable;
    logic chg_active_low;
    dcs_trig_t wake_trig;
    dcs_lw_t level_width;
    logic power_save_en;
    dcs_susp_t suspend_mode;
    logic [6:0] hid_addr;
    logic [15:0] hid_desc_addr;
    dcs_trig_t hid_irq_trig;
    logic hid_idle_sup;
    logic hid_proto_sup;
    logic hid_power_sup;
    dcs_sub_t hid_subclass;
    dcs_proto_t hid_protocol;
  } dcs_cfg_t;

  localparam dcs_cfg_t CFG_DEFAULT = '{
    pull_en: 1'b0,
    chg_disable: 1'b0,
    chg_active_low: 1'b0,
    wake_trig: TRIG_HIGH,
    level_width: LW_30MS,
    power_save_en: 1'b1,
    suspend_mode: SUSP_KEEP,
    hid_addr: HID_ADDR_NONE,
    hid_desc_addr: DESC_ADDR_ZERO,
    hid_irq_trig: TRIG_RISE,
    hid_idle_sup: 1'b0,
    hid_proto_sup: 1'b0,
    hid_power_sup: 1'b0,
    hid_subclass: SUB_NONE,
    hid_protocol: PROTO_NONE
  };

  // loader states, one-hot
  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_READY = 2'b10
  } dcs_load_st_t;

  typedef struct packed {
    dcs_load_st_t state;
    dcs_cfg_t cfg;
    logic ready;
    logic chg_out;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] pull_en;
    logic hid_present;
    logic fetch_valid;
    logic [15:0] fetch_addr;
  } dcs_top_st_t;

  typedef struct packed {
    logic prev;
    logic [31:0] count;
    logic fired;
    logic irq;
  } dcs_wake_st_t;

  typedef struct packed {
    logic [31:0] count;
    logic slow;
  } dcs_idle_st_t;

endpackage : dcs_pkg

// ===== dcs_wake_qual.sv
/*
  Wake/interrupt input qualifier: edge detection or level-width qualification
  of the wake pin, giving a one-cycle interrupt pulse.
  Assumes the pin is already synchronous to clk.
*/
`timescale 1ns/1ps
module dcs_wake_qual #(
  parameter int unsigned W_SHORT = dcs_pkg::LW_SHORT_CYC,
  parameter int unsigned W_MID = dcs_pkg::LW_MID_CYC,
  parameter int unsigned W_LONG = dcs_pkg::LW_LONG_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic pin,
  input dcs_pkg::dcs_trig_t trig,
  input dcs_pkg::dcs_lw_t width,
  output logic irq
);
  import dcs_pkg::*;

  dcs_wake_st_t st;
  dcs_wake_st_t next_st;
  logic [31:0] limit;
  logic active;

  // width selection; the unused code behaves as the longest width
  always_comb begin
    unique case (width)
      LW_1MS: limit = W_SHORT;
      LW_5MS: limit = W_MID;
      default: limit = W_LONG;
    endcase
    active = (trig == TRIG_HIGH) ? pin : ~pin;
  end

  // edge modes fire on the transition; level modes count an unbroken run
  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    next_st.prev = pin;
    if (!enable) begin
      next_st.count = COUNT_ZERO;
      next_st.fired = 1'b0;
    end else begin
      unique case (trig)
        TRIG_RISE: next_st.irq = pin & ~st.prev;
        TRIG_FALL: next_st.irq = ~pin & st.prev;
        TRIG_HIGH, TRIG_LOW: begin
          if (!active) begin
            next_st.count = COUNT_ZERO;
            next_st.fired = 1'b0;
          end else if (st.count == limit) begin
            // one pulse per active period, so a held level does not repeat
            next_st.irq = ~st.fired;
            next_st.fired = 1'b1;
          end else begin
            next_st.count = st.count + COUNT_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irq = st.irq;

  lvl_width_a: assert property (@(posedge clk) disable iff (reset)
    (irq && $past(enable) && $past(trig[1])) |-> $past(st.count) == $past(limit))
    else $error("level interrupt before the selected width");

  lvl_restart_a: assert property (@(posedge clk) disable iff (reset)
    (enable && trig[1] && !active) |=> (st.count == COUNT_ZERO && !irq))
    else $error("level timer not restarted on inactive input");

  rise_edge_a: assert property (@(posedge clk) disable iff (reset)
    (enable && trig == TRIG_RISE && pin && !st.prev) |=> irq)
    else $error("rising edge did not raise the interrupt");

endmodule : dcs_wake_qual

// ===== tb.sv
/*
  Self-checking bench for the option configuration set: loads defaults or
  random records, then checks pulls, charger output, suspend pins, descriptor
  fetch, wake qualification and idle slowing. Assumes shortened timing counts.
*/
`timescale 1ns/1ps
module tb;
  import dcs_pkg::*;
  localparam int unsigned WS = 3, WM = 5, WL = 8, ID = 10;
  logic clk = 1'b0, reset = 1'b1, fitted = 1'b0, extra = 1'b0;
  logic [2:0] delay = 3'h0;
  dcs_cfg_t record = CFG_DEFAULT, cfg_data, active_cfg;
  logic cfg_present, cfg_load, cfg_ready, charger_detect_out, wake_irq, slow_clock_sel;
  logic charger_detected = 1'b0, interrupt_wake_function = 1'b0, wake_irq_pin = 1'b0;
  logic activity = 1'b1, usb_suspend = 1'b0, desc_fetch_req = 1'b0;
  logic [5:0] func_pin_out = 6'h00, func_pin_oe = 6'h00, pin_out, pin_oe, pull_en;
  logic hid_target_present, desc_fetch_valid;
  logic [15:0] desc_fetch_addr;
  int mismatches = 0, checked = 0, cyc = 0, pulses = 0, irq_cyc = 0;

  always #12.5 clk = ~clk;

  dcs_mem_model mem (.clk(clk), .reset(reset), .fitted(fitted), .extra(extra),
    .delay(delay), .record(record), .cfg_present(cfg_present), .cfg_load(cfg_load),
    .cfg_data(cfg_data));

  dcs_config_set #(.W_SHORT(WS), .W_MID(WM), .W_LONG(WL), .IDLE(ID)) dut (.clk(clk),
    .reset(reset), .cfg_present(cfg_present), .cfg_load(cfg_load), .cfg_data(cfg_data),
    .cfg_ready(cfg_ready), .active_cfg(active_cfg), .charger_detected(charger_detected),
    .charger_detect_out(charger_detect_out), .interrupt_wake_function(interrupt_wake_function),
    .wake_irq_pin(wake_irq_pin), .wake_irq(wake_irq), .activity(activity),
    .slow_clock_sel(slow_clock_sel), .usb_suspend(usb_suspend), .func_pin_out(func_pin_out),
    .func_pin_oe(func_pin_oe), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .hid_target_present(hid_target_present), .desc_fetch_req(desc_fetch_req),
    .desc_fetch_valid(desc_fetch_valid), .desc_fetch_addr(desc_fetch_addr));

  // cycle count and wake pulse monitor; pulse width is checked by the count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake_irq === 1'b1) begin
      pulses <= pulses + 1;
      irq_cyc <= cyc;
    end
  end

  task automatic give_verdict();
    $display("counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_cfg(input dcs_cfg_t got, input dcs_cfg_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cfg

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  // expected {oe, out} of the six pins
  function automatic logic [11:0] exp_pins(dcs_susp_t m, logic s, logic [5:0] fo,
                                           logic [5:0] foe);
    if (!s || m == SUSP_KEEP) return {foe, fo};
    case (m)
      SUSP_TRISTATE: return 12'h000;
      SUSP_DRIVE_LOW: return {PINS_ALL, PINS_NONE};
      default: return {PINS_ALL, PINS_ALL};
    endcase
  endfunction : exp_pins

  function automatic logic exp_chg(dcs_cfg_t c, logic d);
    return c.chg_disable ? c.chg_active_low : (d ^ c.chg_active_low);
  endfunction : exp_chg

  // level modes first hold exactly the width (too short), break, then go long
  task automatic wake_case(input dcs_cfg_t c);
    int lim, p0, c0;
    logic act, lvl;
    lim = c.level_width == LW_1MS ? WS : (c.level_width == LW_5MS ? WM : WL);
    act = (c.wake_trig == TRIG_RISE || c.wake_trig == TRIG_HIGH);
    lvl = (c.wake_trig == TRIG_HIGH || c.wake_trig == TRIG_LOW);
    @(posedge clk);
    interrupt_wake_function <= 1'b1;
    wake_irq_pin <= !act;
    step(3);
    p0 = pulses;
    if (lvl) begin
      wake_irq_pin <= act;
      step(lim);
      wake_irq_pin <= !act;
      step(2);
    end
    wake_irq_pin <= act;
    c0 = cyc;
    step(lim + 4);
    wake_irq_pin <= !act;
    interrupt_wake_function <= 1'b0;
    step(4);
    #1;
    cmp_val(pulses - p0, 1);
    cmp_val(irq_cyc - c0, lvl ? lim + 2 : 2);
  endtask : wake_case

  task automatic run_case(input dcs_cfg_t c, input logic fit, input dcs_cfg_t junk);
    logic [5:0] fo, foe;
    int n;
    @(posedge clk);
    fitted <= fit;
    record <= fit ? c : junk;
    extra <= 1'($urandom);
    delay <= 3'($urandom);
    // inputs at rest across reset, so checks started at release see rest levels
    charger_detected <= 1'b0;
    usb_suspend <= 1'b0;
    func_pin_out <= 6'h00;
    func_pin_oe <= 6'h00;
    reset <= 1'b1;
    step(5);
    reset <= 1'b0;
    for (n = 0; n < 50 && cfg_ready !== 1'b1; n++) step(1);
    // a loader that never ends counts once and skips the rest of the case
    if (cfg_ready !== 1'b1) begin
      mismatches++;
      return;
    end
    step(6);
    #1;
    cmp_cfg(active_cfg, c);
    cmp_val(pull_en, c.pull_en ? PINS_ALL : PINS_NONE);
    cmp_val(hid_target_present, c.hid_addr != HID_ADDR_NONE);
    // charger level and suspend pins, both with the input low then high
    for (n = 0; n < 2; n++) begin
      fo = 6'($urandom);
      foe = 6'($urandom);
      @(posedge clk);
      charger_detected <= n[0];
      usb_suspend <= n[0];
      func_pin_out <= fo;
      func_pin_oe <= foe;
      step(2);
      #1;
      cmp_val(charger_detect_out, exp_chg(c, n[0]));
      cmp_val({pin_oe, pin_out}, exp_pins(c.suspend_mode, n[0], fo, foe));
    end
    // descriptor fetch is refused silently with no target
    @(posedge clk);
    desc_fetch_req <= 1'b1;
    @(posedge clk);
    desc_fetch_req <= 1'b0;
    #1;
    cmp_val(desc_fetch_valid, c.hid_addr != HID_ADDR_NONE);
    if (c.hid_addr != HID_ADDR_NONE) cmp_val(desc_fetch_addr, c.hid_desc_addr);
    wake_case(c);
    // idle stretch: slow request at exactly the idle count, gone on activity
    @(posedge clk);
    activity <= 1'b0;
    step(ID - 1);
    #1;
    cmp_val(slow_clock_sel, 1'b0);
    @(posedge clk);
    #1;
    cmp_val(slow_clock_sel, c.power_save_en);
    @(posedge clk);
    activity <= 1'b1;
    @(posedge clk);
    #1;
    cmp_val(slow_clock_sel, 1'b0);
    $display("test done fit=%0d trig=%0d width=%0d", fit, c.wake_trig, c.level_width);
  endtask : run_case

  initial begin
    logic [63:0] rv;
    dcs_cfg_t c;
    void'($urandom(32'h5157));
    rv = {$urandom, $urandom};
    run_case(CFG_DEFAULT, 1'b0, dcs_cfg_t'(rv[$bits(dcs_cfg_t)-1:0]));
    // every trigger with every width code (spare code 3 too), suspend rotated
    for (int i = 0; i < 16; i++) begin
      rv = {$urandom, $urandom};
      c = dcs_cfg_t'(rv[$bits(dcs_cfg_t)-1:0]);
      c.wake_trig = dcs_trig_t'(i % 4);
      c.level_width = dcs_lw_t'(i / 4);
      c.suspend_mode = dcs_susp_t'((i + i / 4) % 4);
      if (i % 3 == 0) c.hid_addr = HID_ADDR_NONE;
      run_case(c, 1'b1, c);
    end
    give_verdict();
  end
endmodule : tb
